/* design/sisg_map.svh */
`ifndef SISG_MAP_SVH
`define SISG_MAP_SVH

// ==========================================================
// peripheral base addresses
`define SISG_SINIT_BASE 32'h4000_0400
`define SISG_FCTL_BASE 32'h4000_0800

// ==========================================================
// register offsets
`define SISG_STAT_OFS 32'h0000_0000
`define SISG_EADDR_OFS 32'h0000_0004
`define SISG_FCTL_OFS 32'h0000_0000

// ==========================================================
// status fields
`define SISG_STAT_ERR_BIT 1
`define SISG_STAT_OK_BIT 0

// ==========================================================
// function control fields
`define SISG_FCTL_B1_CLK_BIT 23
`define SISG_FCTL_B1_DAT_BIT 22
`define SISG_FCTL_B0_CLK_BIT 21
`define SISG_FCTL_B0_DAT_BIT 20
`define SISG_FCTL_WMASK 32'h00ff_ffff
`define SISG_FCTL_RST 32'h0000_0000
`define SISG_EADDR_RST 32'h0000_0000
`define SISG_ZERO_WORD 32'h0000_0000

`endif

/* design/sisg_pkg.sv */
package sisg_pkg;

  typedef logic [31:0] sisg_word_t;

  // register selected by a bus address
  typedef enum logic [1:0] {
    SISG_SEL_NONE = 2'h0,
    SISG_SEL_STAT = 2'h1,
    SISG_SEL_EADDR = 2'h2,
    SISG_SEL_FCTL = 2'h3
  } sisg_sel_t;

  // configuration check outcome, gray along each path out of waiting
  typedef enum logic [1:0] {
    SISG_CFG_WAIT = 2'h0,
    SISG_CFG_OK = 2'h1,
    SISG_CFG_ERR = 2'h2
  } sisg_cfg_state_t;

endpackage

/* design/sisg_supply_mon.sv */
`timescale 1ns/10ps
module sisg_supply_mon
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // monitor enables
  input wire logic core_mon_en,
  input wire logic main_mon_en,
  input wire logic core_pf_en,
  // comparator outputs, asynchronous
  input wire logic core_low_async,
  input wire logic main_low_async,
  input wire logic core_fail_async,
  // responses
  output logic core_domain_rst,
  output logic main_domain_rst,
  output logic chip_por_req,
  output logic pwr_warn_irq
);
  import sisg_pkg::*;

  // ==========================================================
  // synchronisers
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic core_trip;
  logic main_trip;
  logic pf_trip;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {core_fail_async, main_low_async, core_low_async};
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // trip decode; a disabled monitor is blind to its supply
  assign core_trip = sync2_reg[0] & core_mon_en; // [R08]
  assign main_trip = sync2_reg[1] & main_mon_en; // [R08]
  assign pf_trip = sync2_reg[2] & core_pf_en; // [R10]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_domain_rst <= 1'b0;
      main_domain_rst <= 1'b0;
      chip_por_req <= 1'b0;
      pwr_warn_irq <= 1'b0;
    end
    else
    begin
      core_domain_rst <= core_trip; // [R09]
      main_domain_rst <= main_trip; // [R09]
      chip_por_req <= pf_trip; // [R10]
      pwr_warn_irq <= core_trip | main_trip | pf_trip; // [R11]
    end
  end

  // ==========================================================
  // checks
  sequence core_low_seen;
    sync2_reg[0] && core_mon_en;
  endsequence

  sequence core_pf_seen;
    sync2_reg[2] && core_pf_en;
  endsequence

  AST_DOMAIN_RST: assert property (@(posedge clk) disable iff (rst) // [R09]
    core_low_seen |=> core_domain_rst)
    else $error("core domain reset missing after trip");

  AST_MON_OFF: assert property (@(posedge clk) disable iff (rst) // [R08]
    !main_mon_en |=> !main_domain_rst)
    else $error("disabled main monitor caused a reset");

  AST_POR: assert property (@(posedge clk) disable iff (rst) // [R10]
    $rose(core_fail_async) && core_pf_en ##1 core_pf_en ##1 core_pf_en
    |=> chip_por_req)
    else $error("power fail did not request chip reset");

  AST_WARN: assert property (@(posedge clk) disable iff (rst) // [R11]
    core_pf_seen or (sync2_reg[1] && main_mon_en) |=> pwr_warn_irq)
    else $error("warning interrupt not raised on trip");

endmodule

/* design/sisg_top.sv */
// Summary of operation
// R01: a failed reset-time configuration check sets status bit 1.
// R02: a passed reset-time configuration check sets status bit 0.
// R03: on a failed check the error address register holds the failing entry address.
// R04: status and error address registers are read-only; writes leave them unchanged.
// R05: function control bits 23 and 22 enable second bus clock and data filters.
// R06: function control bits 21 and 20 enable first bus clock and data filters.
// R07: software keeps reserved function control fields unchanged when writing.
// R08: core and main supply monitors have separate enables and watch continuously.
// R09: an enabled monitor trip resets that supply domain's registers.
// R10: enabled core power-fail trip requests a whole-chip power-on reset.
// R11: any monitor trip raises the power-fail warning interrupt.
// R12: initialisation status registers decode at base 0x4000_0400.
// R13: function control register decodes at base 0x4000_0800.
// R14: after the check exactly one status flag is set, stable until reset.
`timescale 1ns/10ps
`include "sisg_map.svh"
module sisg_top
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // peripheral bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire sisg_pkg::sisg_word_t paddr,
  input wire sisg_pkg::sisg_word_t pwdata,
  output sisg_pkg::sisg_word_t prdata,
  output logic pready,
  output logic pslverr,
  // configuration check result
  input wire logic cfg_chk_done,
  input wire logic cfg_chk_ok,
  input wire sisg_pkg::sisg_word_t cfg_chk_addr,
  // supply monitor enables
  input wire logic core_mon_en,
  input wire logic main_mon_en,
  input wire logic core_pf_en,
  // supply comparators
  input wire logic core_low_async,
  input wire logic main_low_async,
  input wire logic core_fail_async,
  // supply responses
  output logic core_domain_rst,
  output logic main_domain_rst,
  output logic chip_por_req,
  output logic pwr_warn_irq,
  // serial bus input filter enables
  output logic bus1_clock_line_filter_on,
  output logic bus1_data_line_filter_on,
  output logic bus0_clock_line_filter_on,
  output logic bus0_data_line_filter_on
);
  import sisg_pkg::*;

  // ==========================================================
  // address decode
  function automatic sisg_sel_t sisg_decode(input sisg_word_t addr);
    sisg_sel_t sel;
    sel = SISG_SEL_NONE;
    if (addr == `SISG_SINIT_BASE + `SISG_STAT_OFS)
      sel = SISG_SEL_STAT; // [R12]
    else if (addr == `SISG_SINIT_BASE + `SISG_EADDR_OFS)
      sel = SISG_SEL_EADDR; // [R12]
    else if (addr == `SISG_FCTL_BASE + `SISG_FCTL_OFS)
      sel = SISG_SEL_FCTL; // [R13]
    return sel;
  endfunction

  sisg_sel_t bus_sel;
  logic setup_phase;
  logic access_phase;
  logic fctl_write;

  assign bus_sel = sisg_decode(paddr);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  // status and error address have no write path at all
  assign fctl_write = access_phase & pwrite & (bus_sel == SISG_SEL_FCTL); // [R04]
  assign pready = 1'b1;
  assign pslverr = access_phase & (bus_sel == SISG_SEL_NONE);

  // ==========================================================
  // configuration check capture
  sisg_cfg_state_t cfg_state_reg;
  sisg_cfg_state_t cfg_state_next;
  sisg_word_t eaddr_reg;
  sisg_word_t eaddr_next;
  sisg_word_t stat_word;

  // only the first result after reset counts; later ones are ignored
  always_comb
  begin
    cfg_state_next = cfg_state_reg;
    eaddr_next = eaddr_reg;
    case (cfg_state_reg)
      SISG_CFG_WAIT:
      begin
        if (cfg_chk_done && cfg_chk_ok)
          cfg_state_next = SISG_CFG_OK; // [R02]
        else if (cfg_chk_done)
        begin
          cfg_state_next = SISG_CFG_ERR; // [R01]
          eaddr_next = cfg_chk_addr; // [R03]
        end
      end
      SISG_CFG_OK: cfg_state_next = SISG_CFG_OK; // [R14]
      SISG_CFG_ERR: cfg_state_next = SISG_CFG_ERR; // [R14]
      default: cfg_state_next = SISG_CFG_WAIT;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_state_reg <= SISG_CFG_WAIT;
      eaddr_reg <= `SISG_EADDR_RST;
    end
    else
    begin
      cfg_state_reg <= cfg_state_next;
      eaddr_reg <= eaddr_next;
    end
  end

  always_comb
  begin
    stat_word = `SISG_ZERO_WORD;
    stat_word[`SISG_STAT_ERR_BIT] = (cfg_state_reg == SISG_CFG_ERR); // [R01]
    stat_word[`SISG_STAT_OK_BIT] = (cfg_state_reg == SISG_CFG_OK); // [R02]
  end

  // ==========================================================
  // function control register
  sisg_word_t fctl_reg;
  sisg_word_t fctl_next;

  // reserved low field is stored as written so software read-modify-write
  // round-trips it; top byte never stores anything
  // a core domain trip beats a write landing in the same cycle, since the
  // register sits in the core domain and must not keep a value written at brown-out
  assign fctl_next = core_domain_rst ? `SISG_FCTL_RST : // [R09]
                     fctl_write ? (pwdata & `SISG_FCTL_WMASK) : fctl_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fctl_reg <= `SISG_FCTL_RST;
    else
      fctl_reg <= fctl_next;
  end

  assign bus1_clock_line_filter_on = fctl_reg[`SISG_FCTL_B1_CLK_BIT]; // [R05]
  assign bus1_data_line_filter_on = fctl_reg[`SISG_FCTL_B1_DAT_BIT]; // [R05]
  assign bus0_clock_line_filter_on = fctl_reg[`SISG_FCTL_B0_CLK_BIT]; // [R06]
  assign bus0_data_line_filter_on = fctl_reg[`SISG_FCTL_B0_DAT_BIT]; // [R06]

  // ==========================================================
  // read data, captured in setup so it is steady through access
  sisg_word_t rd_mux;
  sisg_word_t prdata_next;

  always_comb
  begin
    case (bus_sel)
      SISG_SEL_STAT: rd_mux = stat_word;
      SISG_SEL_EADDR: rd_mux = eaddr_reg;
      SISG_SEL_FCTL: rd_mux = fctl_reg;
      default: rd_mux = `SISG_ZERO_WORD;
    endcase
  end

  assign prdata_next = setup_phase ? rd_mux : prdata;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata <= `SISG_ZERO_WORD;
    else
      prdata <= prdata_next;
  end

  // ==========================================================
  // supply monitoring
  sisg_supply_mon u_supply_mon
  (
    .clk(clk),
    .rst(rst),
    .core_mon_en(core_mon_en),
    .main_mon_en(main_mon_en),
    .core_pf_en(core_pf_en),
    .core_low_async(core_low_async),
    .main_low_async(main_low_async),
    .core_fail_async(core_fail_async),
    .core_domain_rst(core_domain_rst),
    .main_domain_rst(main_domain_rst),
    .chip_por_req(chip_por_req),
    .pwr_warn_irq(pwr_warn_irq)
  );

  // ==========================================================
  // checks
  sequence chk_fail_in_wait;
    cfg_state_reg == SISG_CFG_WAIT && cfg_chk_done && !cfg_chk_ok;
  endsequence

  sequence chk_pass_in_wait;
    cfg_state_reg == SISG_CFG_WAIT && cfg_chk_done && cfg_chk_ok;
  endsequence

  sequence fctl_wr_seq;
    psel && penable && pwrite && paddr == `SISG_FCTL_BASE && !core_domain_rst;
  endsequence

  sequence sinit_wr_seq;
    psel && penable && pwrite && bus_sel inside {SISG_SEL_STAT, SISG_SEL_EADDR};
  endsequence

  // setup phase aimed at an address that no register answers to
  sequence unmapped_setup;
    psel && !penable && bus_sel == SISG_SEL_NONE;
  endsequence

  AST_CFG_ERR: assert property (@(posedge clk) disable iff (rst) // [R01]
    chk_fail_in_wait |=> stat_word[`SISG_STAT_ERR_BIT] && !stat_word[`SISG_STAT_OK_BIT])
    else $error("error flag not set after failed check");

  AST_CFG_OK: assert property (@(posedge clk) disable iff (rst) // [R02]
    chk_pass_in_wait |=> stat_word[`SISG_STAT_OK_BIT] && !stat_word[`SISG_STAT_ERR_BIT])
    else $error("ok flag not set after passed check");

  // the window ends eight edges after the failing check, so look back eight
  AST_EADDR: assert property (@(posedge clk) disable iff (rst) // [R03]
    chk_fail_in_wait ##1 1'b1 [*8] |-> eaddr_reg == $past(cfg_chk_addr, 8))
    else $error("error address not held");

  AST_EADDR_IDLE: assert property (@(posedge clk) disable iff (rst) // [R03]
    cfg_state_reg != SISG_CFG_ERR |-> eaddr_reg == `SISG_EADDR_RST)
    else $error("error address set without a failed check");

  AST_EADDR_RD: assert property (@(posedge clk) disable iff (rst) // [R03]
    psel && !penable && bus_sel == SISG_SEL_EADDR ##1 psel && penable
    |-> prdata == $past(eaddr_reg) && !pslverr)
    else $error("error address read data wrong");

  AST_RO: assert property (@(posedge clk) disable iff (rst) // [R04]
    sinit_wr_seq and cfg_state_reg != SISG_CFG_WAIT
    |=> $stable(stat_word) && $stable(eaddr_reg))
    else $error("read-only register changed on write");

  AST_FLT_BUS1: assert property (@(posedge clk) disable iff (rst) // [R05]
    fctl_wr_seq |=> bus1_clock_line_filter_on == $past(pwdata[`SISG_FCTL_B1_CLK_BIT])
      && bus1_data_line_filter_on == $past(pwdata[`SISG_FCTL_B1_DAT_BIT]))
    else $error("second bus filter enables wrong");

  AST_FLT_BUS0: assert property (@(posedge clk) disable iff (rst) // [R06]
    fctl_wr_seq |=> bus0_clock_line_filter_on == $past(pwdata[`SISG_FCTL_B0_CLK_BIT])
      && bus0_data_line_filter_on == $past(pwdata[`SISG_FCTL_B0_DAT_BIT]))
    else $error("first bus filter enables wrong");

  AST_FCTL_TOP: assert property (@(posedge clk) disable iff (rst) // [R07]
    (fctl_reg & ~`SISG_FCTL_WMASK) == `SISG_ZERO_WORD)
    else $error("reserved top byte stored a value");

  AST_SINIT_RD: assert property (@(posedge clk) disable iff (rst) // [R12]
    psel && !penable && paddr == `SISG_SINIT_BASE ##1 psel && penable
    |-> prdata == $past(stat_word))
    else $error("status read data wrong");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (rst) // [R12]
    unmapped_setup ##1 psel && penable |-> pslverr && prdata == `SISG_ZERO_WORD)
    else $error("unmapped access not refused");

  // read data is loaded in setup only, so it cannot move under the master
  AST_RD_HOLD: assert property (@(posedge clk) disable iff (rst) // [R12]
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside a setup phase");

  AST_FCTL_RD: assert property (@(posedge clk) disable iff (rst) // [R13]
    psel && !penable && paddr == `SISG_FCTL_BASE ##1 psel && penable
    |-> prdata == $past(fctl_reg) && !pslverr)
    else $error("function control read wrong");

  AST_FCTL_KEEP: assert property (@(posedge clk) disable iff (rst) // [R13]
    !(psel && penable && pwrite) && !core_domain_rst |=> $stable(fctl_reg))
    else $error("function control changed without a write");

  AST_ONE_FLAG: assert property (@(posedge clk) disable iff (rst) // [R14]
    cfg_state_reg != SISG_CFG_WAIT
    |=> (stat_word[`SISG_STAT_ERR_BIT] ^ stat_word[`SISG_STAT_OK_BIT]) && $stable(stat_word))
    else $error("status flags not exclusive or not stable");

  AST_WAIT_ZERO: assert property (@(posedge clk) disable iff (rst) // [R14]
    cfg_state_reg == SISG_CFG_WAIT |-> stat_word == `SISG_ZERO_WORD)
    else $error("status flag set before the check completed");

  AST_DOM_CLR: assert property (@(posedge clk) disable iff (rst) // [R09]
    core_domain_rst |=> fctl_reg == `SISG_FCTL_RST)
    else $error("core domain reset did not clear control");

endmodule

/* tb/tb_sisg_top.sv */
`timescale 1ns/10ps
`include "sisg_map.svh"
// ==========================================================
// compare helper
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_sisg_top;
  import sisg_pkg::*;
  localparam sisg_word_t STAT = `SISG_SINIT_BASE + `SISG_STAT_OFS;
  localparam sisg_word_t EADR = `SISG_SINIT_BASE + `SISG_EADDR_OFS;
  localparam sisg_word_t FCTL = `SISG_FCTL_BASE + `SISG_FCTL_OFS;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, cfg_chk_done, cfg_chk_ok;
  sisg_word_t paddr, pwdata, prdata, cfg_chk_addr, rv;
  logic core_mon_en, main_mon_en, core_pf_en, core_low_async, main_low_async, core_fail_async;
  logic core_domain_rst, main_domain_rst, chip_por_req, pwr_warn_irq;
  logic b1c, b1d, b0c, b0d, ev;
  int n_fail, comparisons;
  sisg_top u_sisg_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_chk_done(cfg_chk_done), .cfg_chk_ok(cfg_chk_ok),
    .cfg_chk_addr(cfg_chk_addr), .core_mon_en(core_mon_en), .main_mon_en(main_mon_en),
    .core_pf_en(core_pf_en), .core_low_async(core_low_async),
    .main_low_async(main_low_async), .core_fail_async(core_fail_async),
    .core_domain_rst(core_domain_rst), .main_domain_rst(main_domain_rst),
    .chip_por_req(chip_por_req), .pwr_warn_irq(pwr_warn_irq),
    .bus1_clock_line_filter_on(b1c), .bus1_data_line_filter_on(b1d),
    .bus0_clock_line_filter_on(b0c), .bus0_data_line_filter_on(b0d));
  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    // tests need well under 500 cycles
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // bus tasks: setup, access, sample at the edge where pready is high
  task automatic apb(input logic wr, input sisg_word_t a, input sisg_word_t d);
    @(negedge clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev = pslverr;
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
    pwdata = ~d;
  endtask
  task automatic rd(input string w, input sisg_word_t a, input sisg_word_t e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(w, e, rv)
    `CHK("slave error", ee, ev)
  endtask
  task automatic wr(input sisg_word_t a, input sisg_word_t d, input logic ee);
    apb(1'b1, a, d);
    `CHK("write error", ee, ev)
  endtask
  task automatic filt(input logic [3:0] e);
    `CHK("filters", e, {b1c, b1d, b0c, b0d})
  endtask
  // ==========================================================
  // reset, configuration result, supply stimulus
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic cfg(input logic ok, input sisg_word_t a);
    @(negedge clk);
    cfg_chk_done = 1'b1;
    cfg_chk_ok = ok;
    cfg_chk_addr = a;
    @(negedge clk);
    cfg_chk_done = 1'b0;
    cfg_chk_ok = ~ok;
    cfg_chk_addr = ~a;
  endtask
  // comparators pass two sync stages and a register: three edges
  task automatic sup(input logic [2:0] en, input logic [2:0] low, input logic [3:0] e);
    @(negedge clk);
    {core_mon_en, main_mon_en, core_pf_en} = en;
    @(negedge clk);
    {core_low_async, main_low_async, core_fail_async} = low;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("supply", e, {core_domain_rst, main_domain_rst, chip_por_req, pwr_warn_irq})
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    rst = 1'b1;
    {psel, penable, pwrite, cfg_chk_done, cfg_chk_ok} = 5'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    cfg_chk_addr = 32'h0000_0000;
    {core_mon_en, main_mon_en, core_pf_en} = 3'h0;
    {core_low_async, main_low_async, core_fail_async} = 3'h0;
    do_reset();
    rd("status before check", STAT, 32'h0000_0000, 1'b0);
    rd("fctl reset", FCTL, `SISG_FCTL_RST, 1'b0);
    filt(4'h0);
    $display("test reset_values done");
    cfg(1'b0, 32'h0000_1a2c);
    rd("status fail", STAT, 32'h0000_0002, 1'b0);
    rd("error address", EADR, 32'h0000_1a2c, 1'b0);
    cfg(1'b1, 32'h0000_0040);
    rd("status second check", STAT, 32'h0000_0002, 1'b0);
    wr(STAT, 32'hffff_ffff, 1'b0);
    wr(EADR, 32'h0000_0000, 1'b0);
    rd("status after write", STAT, 32'h0000_0002, 1'b0);
    rd("address after write", EADR, 32'h0000_1a2c, 1'b0);
    do_reset();
    cfg(1'b1, 32'h0000_0bad);
    rd("status pass", STAT, 32'h0000_0001, 1'b0);
    cfg(1'b0, 32'h0000_0bad);
    rd("status pass kept", STAT, 32'h0000_0001, 1'b0);
    $display("test config_check done");
    for (int i = 0; i < 4; i++)
    begin
      wr(FCTL, (32'h0010_0000 << i) | 32'h0000_0005, 1'b0);
      rd("fctl bit", FCTL, (32'h0010_0000 << i) | 32'h0000_0005, 1'b0);
      filt(4'h1 << i);
    end
    apb(1'b0, FCTL, 32'h0000_0000);
    wr(FCTL, (rv & 32'hff0f_ffff) | 32'h00c0_0000, 1'b0);
    rd("fctl modify", FCTL, 32'h00c0_0005, 1'b0);
    filt(4'hc);
    wr(FCTL, 32'hffff_ffff, 1'b0);
    rd("fctl reserved high", FCTL, 32'h00ff_ffff, 1'b0);
    filt(4'hf);
    $display("test function_control done");
    rd("unmapped read", 32'h4000_0408, 32'h0000_0000, 1'b1);
    rd("unmapped fctl+4", 32'h4000_0804, 32'h0000_0000, 1'b1);
    wr(32'h4000_0c00, 32'h0000_0000, 1'b1);
    rd("fctl kept", FCTL, 32'h00ff_ffff, 1'b0);
    $display("test unmapped done");
    sup(3'b000, 3'b111, 4'b0000);
    sup(3'b100, 3'b100, 4'b1001);
    sup(3'b100, 3'b000, 4'b0000);
    rd("fctl after domain reset", FCTL, `SISG_FCTL_RST, 1'b0);
    filt(4'h0);
    sup(3'b010, 3'b110, 4'b0101);
    sup(3'b010, 3'b000, 4'b0000);
    sup(3'b001, 3'b001, 4'b0011);
    sup(3'b000, 3'b001, 4'b0000);
    $display("test supply done");
    stop_test();
  end
endmodule
